// >>> design/ipl_prio_regs.sv
// Priority level registers five to eight with per-source level outputs
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
// Function
// - Field codes: off, level 0, 1, 2
// - Every field resets to disabled
// - Reserved bits read zero, ignore writes
// - Register five field placement
// - Register six field placement
// - Decoder home field shared with watchdog
// - Register seven field placement
// - Register eight upper field placement
// - Register eight lower field placement
module ipl_prio_regs
   import ipl_pkg::*;
(
   input  wire logic                         clk_sys,
   input  wire logic                         rstn,
   input  wire logic [ipl_pkg::ADDR_W-1:0]   reg_addr,
   input  wire logic [ipl_pkg::DATA_W-1:0]   reg_wdata,
   input  wire logic                         reg_wr,
   input  wire logic                         reg_rd,
   output logic [ipl_pkg::DATA_W-1:0]        reg_rdata,
   output ipl_pkg::ipl_level_t               serial1_rx_error_level,
   output ipl_pkg::ipl_level_t               serial1_tx_idle_level,
   output ipl_pkg::ipl_level_t               serial1_tx_empty_level,
   output ipl_pkg::ipl_level_t               spi_port0_tx_empty_level,
   output ipl_pkg::ipl_level_t               timer_c_ch0_level,
   output ipl_pkg::ipl_level_t               timer_d_ch3_level,
   output ipl_pkg::ipl_level_t               timer_d_ch2_level,
   output ipl_pkg::ipl_level_t               timer_d_ch1_level,
   output ipl_pkg::ipl_level_t               timer_d_ch0_level,
   output ipl_pkg::ipl_level_t               decoder0_index_level,
   output ipl_pkg::ipl_level_t               decoder0_home_level,
   output ipl_pkg::ipl_level_t               decoder0_watchdog_level,
   output ipl_pkg::ipl_level_t               timer_a_ch0_level,
   output ipl_pkg::ipl_level_t               timer_b_ch3_level,
   output ipl_pkg::ipl_level_t               timer_b_ch2_level,
   output ipl_pkg::ipl_level_t               timer_b_ch1_level,
   output ipl_pkg::ipl_level_t               timer_b_ch0_level,
   output ipl_pkg::ipl_level_t               timer_c_ch3_level,
   output ipl_pkg::ipl_level_t               timer_c_ch2_level,
   output ipl_pkg::ipl_level_t               timer_c_ch1_level,
   output ipl_pkg::ipl_level_t               serial0_rx_full_level,
   output ipl_pkg::ipl_level_t               serial0_rx_error_level,
   output ipl_pkg::ipl_level_t               serial0_tx_idle_level,
   output ipl_pkg::ipl_level_t               serial0_tx_empty_level,
   output ipl_pkg::ipl_level_t               timer_a_ch3_level,
   output ipl_pkg::ipl_level_t               timer_a_ch2_level,
   output ipl_pkg::ipl_level_t               timer_a_ch1_level,
   output logic [ipl_pkg::NUM_FLD-1:0]       src_enabled,
   output logic [2*ipl_pkg::NUM_FLD-1:0]     src_rank
);

   import ipl_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Field storage and decode

   ipl_level_t              lvl [0:NUM_FLD-1];
   logic [DATA_W-1:0]       word_five;
   logic [DATA_W-1:0]       word_six;
   logic [DATA_W-1:0]       word_seven;
   logic [DATA_W-1:0]       word_eight;
   logic [DATA_W-1:0]       nxt_rdata;
   logic [DATA_W-1:0]       rdata_ff;

   genvar g;
   generate
      for (g = 0; g < NUM_FLD; g = g + 1)
      begin : gen_fld
         logic       fld_wr;
         ipl_level_t fld_rank;

         // Only the field's own bit pair is taken; reserved pairs have no storage
         assign fld_wr = reg_wr && (reg_addr == FLD_OFF[g]);

         ipl_field_reg u_fld (
            .clk_sys (clk_sys),
            .rstn    (rstn),
            .wr_en   (fld_wr),
            .wr_lvl  (reg_wdata[FLD_LSB[g] +: LVL_W]),
            .lvl_ff  (lvl[g])
         );

         ipl_level_dec u_dec (
            .lvl     (lvl[g]),
            .enabled (src_enabled[g]),
            .rank    (fld_rank)
         );

         assign src_rank[2*g +: 2] = fld_rank;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Level outputs straight from the field flops

   assign serial1_rx_error_level   = lvl[F_S1_RXERR];
   assign serial1_tx_idle_level    = lvl[F_S1_TIDLE];
   assign serial1_tx_empty_level   = lvl[F_S1_TXEMP];
   assign spi_port0_tx_empty_level = lvl[F_SPI0_TXE];
   assign timer_c_ch0_level        = lvl[F_TC0];
   assign timer_d_ch3_level        = lvl[F_TD3];
   assign timer_d_ch2_level        = lvl[F_TD2];
   assign timer_d_ch1_level        = lvl[F_TD1];
   assign timer_d_ch0_level        = lvl[F_TD0];
   assign decoder0_index_level     = lvl[F_DEC0_IDX];
   // Home transition and watchdog timeout share one field
   assign decoder0_home_level      = lvl[F_DEC0_HOME];
   assign decoder0_watchdog_level  = lvl[F_DEC0_HOME];
   assign timer_a_ch0_level        = lvl[F_TA0];
   assign timer_b_ch3_level        = lvl[F_TB3];
   assign timer_b_ch2_level        = lvl[F_TB2];
   assign timer_b_ch1_level        = lvl[F_TB1];
   assign timer_b_ch0_level        = lvl[F_TB0];
   assign timer_c_ch3_level        = lvl[F_TC3];
   assign timer_c_ch2_level        = lvl[F_TC2];
   assign timer_c_ch1_level        = lvl[F_TC1];
   assign serial0_rx_full_level    = lvl[F_S0_RXFUL];
   assign serial0_rx_error_level   = lvl[F_S0_RXERR];
   assign serial0_tx_idle_level    = lvl[F_S0_TIDLE];
   assign serial0_tx_empty_level   = lvl[F_S0_TXEMP];
   assign timer_a_ch3_level        = lvl[F_TA3];
   assign timer_a_ch2_level        = lvl[F_TA2];
   assign timer_a_ch1_level        = lvl[F_TA1];

   ////////////////////////////////////////////////////////////////////////
   // Read words; unimplemented pairs are constant zero

   assign word_five = {6'h00,
                       lvl[F_S1_RXERR],
                       2'h0,
                       lvl[F_S1_TIDLE],
                       lvl[F_S1_TXEMP],
                       lvl[F_SPI0_TXE]};

   assign word_six = {lvl[F_TC0],
                      lvl[F_TD3],
                      lvl[F_TD2],
                      lvl[F_TD1],
                      lvl[F_TD0],
                      2'h0,
                      lvl[F_DEC0_IDX],
                      lvl[F_DEC0_HOME]};

   assign word_seven = {lvl[F_TA0],
                        lvl[F_TB3],
                        lvl[F_TB2],
                        lvl[F_TB1],
                        lvl[F_TB0],
                        lvl[F_TC3],
                        lvl[F_TC2],
                        lvl[F_TC1]};

   assign word_eight = {lvl[F_S0_RXFUL],
                        lvl[F_S0_RXERR],
                        2'h0,
                        lvl[F_S0_TIDLE],
                        lvl[F_S0_TXEMP],
                        lvl[F_TA3],
                        lvl[F_TA2],
                        lvl[F_TA1]};

   ////////////////////////////////////////////////////////////////////////
   // Register port read path: data in the cycle after the strobe only

   always_comb
   begin
      nxt_rdata = RST_WORD;
      if (reg_addr == OFF_FIVE)
      begin
         nxt_rdata = word_five;
      end
      else if (reg_addr == OFF_SIX)
      begin
         nxt_rdata = word_six;
      end
      else if (reg_addr == OFF_SEVEN)
      begin
         nxt_rdata = word_seven;
      end
      else if (reg_addr == OFF_EIGHT)
      begin
         nxt_rdata = word_eight;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         rdata_ff <= RST_WORD;
      end
      else if (reg_rd)
      begin
         rdata_ff <= nxt_rdata;
      end
      else
      begin
         rdata_ff <= RST_WORD;
      end
   end

   assign reg_rdata = rdata_ff;

   ////////////////////////////////////////////////////////////////////////
   // Checks: previous-cycle bus capture for write checks and the read timing check

   logic [ADDR_W-1:0] chk_addr_ff;
   logic [DATA_W-1:0] chk_wdata_ff;
   logic              chk_wr_ff;
   logic              chk_rd_ff;

   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         chk_addr_ff  <= '0;
         chk_wdata_ff <= RST_WORD;
         chk_wr_ff    <= 1'b0;
         chk_rd_ff    <= 1'b0;
      end
      else
      begin
         chk_addr_ff  <= reg_addr;
         chk_wdata_ff <= reg_wdata;
         chk_wr_ff    <= reg_wr;
         chk_rd_ff    <= reg_rd;
      end
   end

   default clocking chk_cb @(posedge clk_sys);
   endclocking

   default disable iff (!rstn);

   reset_clear_a: assert property (disable iff (1'b0)
      !rstn |=> (src_enabled == '0) && (src_rank == '0) && (reg_rdata == RST_WORD))
      else $error("levels not disabled after reset");

   code_map_a: assert property (
      (src_enabled[F_TD1] == (timer_d_ch1_level != LVL_OFF)) &&
      (src_rank[2*F_TD1 +: 2] != LVL_2) &&
      ((timer_d_ch1_level == LVL_2) -> (src_rank[2*F_TD1 +: 2] == LVL_1)))
      else $error("level code decoded wrongly");

   masked_echo_a: assert property (
      (reg_wr && reg_addr == OFF_FIVE) ##1 (reg_rd && reg_addr == OFF_FIVE)
      |=> reg_rdata == ($past(reg_wdata, 2) & MASK_FIVE))
      else $error("reserved bits of register five not zero");

   five_map_a: assert property (
      (chk_wr_ff && chk_addr_ff == OFF_FIVE) |->
      (serial1_rx_error_level == chk_wdata_ff[9:8]) &&
      (spi_port0_tx_empty_level == chk_wdata_ff[1:0]))
      else $error("register five field misplaced");

   six_map_a: assert property (
      (chk_wr_ff && chk_addr_ff == OFF_SIX) |->
      (timer_c_ch0_level == chk_wdata_ff[15:14]) &&
      (timer_d_ch0_level == chk_wdata_ff[7:6]) &&
      (decoder0_index_level == chk_wdata_ff[3:2]))
      else $error("register six field misplaced");

   home_shared_a: assert property (
      (chk_wr_ff && chk_addr_ff == OFF_SIX) |->
      (decoder0_home_level == chk_wdata_ff[1:0]) &&
      (decoder0_watchdog_level == chk_wdata_ff[1:0]))
      else $error("decoder home and watchdog levels differ");

   seven_map_a: assert property (
      (chk_wr_ff && chk_addr_ff == OFF_SEVEN) |->
      (timer_a_ch0_level == chk_wdata_ff[15:14]) &&
      (timer_b_ch3_level == chk_wdata_ff[13:12]) &&
      (timer_c_ch3_level == chk_wdata_ff[5:4]))
      else $error("register seven field misplaced");

   eight_high_a: assert property (
      (chk_wr_ff && chk_addr_ff == OFF_EIGHT) |->
      (serial0_rx_full_level == chk_wdata_ff[15:14]) &&
      (serial0_rx_error_level == chk_wdata_ff[13:12]) &&
      (serial0_tx_idle_level == chk_wdata_ff[9:8]))
      else $error("register eight upper field misplaced");

   eight_low_a: assert property (
      (chk_wr_ff && chk_addr_ff == OFF_EIGHT) |->
      (serial0_tx_empty_level == chk_wdata_ff[7:6]) &&
      (timer_a_ch3_level == chk_wdata_ff[5:4]) &&
      (timer_a_ch1_level == chk_wdata_ff[1:0]))
      else $error("register eight lower field misplaced");

   level_hold_a: assert property (
      !(reg_wr && reg_addr == OFF_SEVEN) |=> $stable(timer_b_ch1_level))
      else $error("level changed without a write");

   read_timing_a: assert property (
      !chk_rd_ff |-> reg_rdata == RST_WORD)
      else $error("read data outside the answer cycle");

   read_six_a: assert property (
      (reg_rd && reg_addr == OFF_SIX) |=>
      (reg_rdata[5:4] == 2'h0) && (reg_rdata[15:14] == $past(timer_c_ch0_level)))
      else $error("register six read back wrong");

   five_low_a: assert property (
      (chk_wr_ff && chk_addr_ff == OFF_FIVE) |->
      (serial1_tx_idle_level == chk_wdata_ff[5:4]) &&
      (serial1_tx_empty_level == chk_wdata_ff[3:2]))
      else $error("register five lower field misplaced");

   six_timer_a: assert property (
      (chk_wr_ff && chk_addr_ff == OFF_SIX) |->
      (timer_d_ch3_level == chk_wdata_ff[13:12]) &&
      (timer_d_ch2_level == chk_wdata_ff[11:10]) &&
      (timer_d_ch1_level == chk_wdata_ff[9:8]))
      else $error("register six timer field misplaced");

   seven_low_a: assert property (
      (chk_wr_ff && chk_addr_ff == OFF_SEVEN) |->
      (timer_b_ch2_level == chk_wdata_ff[11:10]) &&
      (timer_b_ch1_level == chk_wdata_ff[9:8]) &&
      (timer_b_ch0_level == chk_wdata_ff[7:6]) &&
      (timer_c_ch2_level == chk_wdata_ff[3:2]) &&
      (timer_c_ch1_level == chk_wdata_ff[1:0]))
      else $error("register seven lower field misplaced");

   eight_timer_a: assert property (
      (chk_wr_ff && chk_addr_ff == OFF_EIGHT) |->
      (timer_a_ch2_level == chk_wdata_ff[3:2]))
      else $error("register eight timer field misplaced");

   unmapped_write_a: assert property (
      (reg_wr && ((reg_addr < OFF_FIVE) || (reg_addr > OFF_EIGHT))) |=>
      $stable(src_enabled) && $stable(src_rank))
      else $error("write outside the map changed a level");

   reserved_read_a: assert property (
      (reg_rd && (reg_addr == OFF_FIVE)) |=> ((reg_rdata & ~MASK_FIVE) == RST_WORD))
      else $error("register five reserved bits set on read");

   unmapped_read_a: assert property (
      (reg_rd && ((reg_addr < OFF_FIVE) || (reg_addr > OFF_EIGHT))) |=> (reg_rdata == RST_WORD))
      else $error("read outside the map not zero");

   eight_reserved_a: assert property (
      (reg_rd && (reg_addr == OFF_EIGHT)) |=> ((reg_rdata & ~MASK_EIGHT) == RST_WORD))
      else $error("register eight reserved bits set on read");

endmodule : ipl_prio_regs

// >>> design/ipl_pkg.sv
// Shared constants for the interrupt priority level register block
package ipl_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Bus and field widths
   localparam int ADDR_W  = 4;
   localparam int DATA_W  = 16;
   localparam int LVL_W   = 2;
   localparam int NUM_FLD = 26;

   typedef logic [LVL_W-1:0] ipl_level_t;

   ////////////////////////////////////////////////////////////////////////
   // Register offsets (word index on the register port)
   localparam logic [ADDR_W-1:0] OFF_FIVE  = 4'h5;
   localparam logic [ADDR_W-1:0] OFF_SIX   = 4'h6;
   localparam logic [ADDR_W-1:0] OFF_SEVEN = 4'h7;
   localparam logic [ADDR_W-1:0] OFF_EIGHT = 4'h8;

   // Reset values and implemented-bit masks
   localparam logic [DATA_W-1:0] RST_WORD   = 16'h0000;
   localparam logic [DATA_W-1:0] MASK_FIVE  = 16'h033F;
   localparam logic [DATA_W-1:0] MASK_SIX   = 16'hFFCF;
   localparam logic [DATA_W-1:0] MASK_SEVEN = 16'hFFFF;
   localparam logic [DATA_W-1:0] MASK_EIGHT = 16'hF3FF;

   ////////////////////////////////////////////////////////////////////////
   // Level encodings
   localparam ipl_level_t LVL_OFF = 2'h0;
   localparam ipl_level_t LVL_0   = 2'h1;
   localparam ipl_level_t LVL_1   = 2'h2;
   localparam ipl_level_t LVL_2   = 2'h3;
   localparam ipl_level_t RST_LVL = 2'h0;

   ////////////////////////////////////////////////////////////////////////
   // Field indices
   localparam int F_S1_RXERR = 0, F_S1_TIDLE = 1, F_S1_TXEMP = 2, F_SPI0_TXE = 3;
   localparam int F_TC0 = 4, F_TD3 = 5, F_TD2 = 6, F_TD1 = 7, F_TD0 = 8;
   localparam int F_DEC0_IDX = 9, F_DEC0_HOME = 10;
   localparam int F_TA0 = 11, F_TB3 = 12, F_TB2 = 13, F_TB1 = 14, F_TB0 = 15;
   localparam int F_TC3 = 16, F_TC2 = 17, F_TC1 = 18;
   localparam int F_S0_RXFUL = 19, F_S0_RXERR = 20, F_S0_TIDLE = 21, F_S0_TXEMP = 22;
   localparam int F_TA3 = 23, F_TA2 = 24, F_TA1 = 25;

   // Register holding each field, and its low bit
   localparam logic [ADDR_W-1:0] FLD_OFF [0:NUM_FLD-1] = '{
      4'h5, 4'h5, 4'h5, 4'h5,
      4'h6, 4'h6, 4'h6, 4'h6, 4'h6, 4'h6, 4'h6,
      4'h7, 4'h7, 4'h7, 4'h7, 4'h7, 4'h7, 4'h7, 4'h7,
      4'h8, 4'h8, 4'h8, 4'h8, 4'h8, 4'h8, 4'h8};
   localparam int FLD_LSB [0:NUM_FLD-1] = '{
      8, 4, 2, 0,
      14, 12, 10, 8, 6, 2, 0,
      14, 12, 10, 8, 6, 4, 2, 0,
      14, 12, 8, 6, 4, 2, 0};

endpackage : ipl_pkg

// >>> design/ipl_field_reg.sv
// One 2-bit priority level field with write enable
`timescale 1ns/1ps
module ipl_field_reg
   import ipl_pkg::*;
(
   input  wire logic          clk_sys,
   input  wire logic          rstn,
   input  wire logic          wr_en,
   input  wire ipl_pkg::ipl_level_t wr_lvl,
   output ipl_pkg::ipl_level_t lvl_ff
);

   import ipl_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Field storage, cleared to disabled by reset
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         lvl_ff <= RST_LVL;
      end
      else if (wr_en)
      begin
         lvl_ff <= wr_lvl;
      end
   end

endmodule : ipl_field_reg

// >>> design/ipl_level_dec.sv
// Splits a level field into enable and level rank
`timescale 1ns/1ps
module ipl_level_dec
   import ipl_pkg::*;
(
   input  ipl_pkg::ipl_level_t lvl,
   output logic                enabled,
   output ipl_pkg::ipl_level_t rank
);

   import ipl_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Code 00 disables; 01..11 give rank 0..2, never above 2
   always_comb
   begin
      enabled = (lvl != LVL_OFF);
      rank    = LVL_OFF;
      if (lvl != LVL_OFF)
      begin
         rank = ipl_level_t'(lvl - LVL_0);
      end
   end

endmodule : ipl_level_dec

// >>> verification/ipl_resolver_model.sv
// Behavioural priority resolver on the far side of the level outputs
`timescale 1ns/1ps
module ipl_resolver_model
   import ipl_pkg::*;
(
   input  wire logic [ipl_pkg::NUM_FLD-1:0]   src_enabled,
   input  wire logic [2*ipl_pkg::NUM_FLD-1:0] src_rank,
   output ipl_pkg::ipl_level_t                top_level
);
   import ipl_pkg::*;
   // Highest code among enabled sources, off when none is enabled
   always_comb
   begin
      top_level = LVL_OFF;
      for (int i = 0; i < NUM_FLD; i++)
         if (src_enabled[i] && (src_rank[2*i+:2] + 2'h1) > top_level)
            top_level = src_rank[2*i+:2] + 2'h1;
   end
endmodule : ipl_resolver_model

// >>> verification/irq_priority_level_regs_tb.sv
// Self-checking bench for the priority level registers
`timescale 1ns/1ps
module irq_priority_level_regs_tb;
   import ipl_pkg::*;
   localparam int OFFS [0:25] = '{5,5,5,5, 6,6,6,6,6,6,6, 7,7,7,7,7,7,7,7, 8,8,8,8,8,8,8};
   localparam int LSBS [0:25] = '{8,4,2,0, 14,12,10,8,6,2,0, 14,12,10,8,6,4,2,0, 14,12,8,6,4,2,0};
   logic              clk_sys;
   logic              rstn;
   logic [3:0]        reg_addr;
   logic [15:0]       reg_wdata;
   logic              reg_wr;
   logic              reg_rd;
   logic [15:0]       reg_rdata;
   ipl_level_t        lv [0:25];
   ipl_level_t        dog;
   ipl_level_t        top_level;
   logic [25:0]       src_enabled;
   logic [51:0]       src_rank;
   logic [15:0]       m [5:8];
   int                n_errors;
   int                checks;
   int                cycles;

   ////////////////////////////////////////////////////////////////////////
   ipl_prio_regs dut_u (
      .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .serial1_rx_error_level(lv[0]), .serial1_tx_idle_level(lv[1]), .serial1_tx_empty_level(lv[2]),
      .spi_port0_tx_empty_level(lv[3]), .timer_c_ch0_level(lv[4]), .timer_d_ch3_level(lv[5]),
      .timer_d_ch2_level(lv[6]), .timer_d_ch1_level(lv[7]), .timer_d_ch0_level(lv[8]),
      .decoder0_index_level(lv[9]), .decoder0_home_level(lv[10]), .decoder0_watchdog_level(dog),
      .timer_a_ch0_level(lv[11]), .timer_b_ch3_level(lv[12]), .timer_b_ch2_level(lv[13]),
      .timer_b_ch1_level(lv[14]), .timer_b_ch0_level(lv[15]), .timer_c_ch3_level(lv[16]),
      .timer_c_ch2_level(lv[17]), .timer_c_ch1_level(lv[18]), .serial0_rx_full_level(lv[19]),
      .serial0_rx_error_level(lv[20]), .serial0_tx_idle_level(lv[21]), .serial0_tx_empty_level(lv[22]),
      .timer_a_ch3_level(lv[23]), .timer_a_ch2_level(lv[24]), .timer_a_ch1_level(lv[25]),
      .src_enabled(src_enabled), .src_rank(src_rank));

   ipl_resolver_model far_u (.src_enabled(src_enabled), .src_rank(src_rank), .top_level(top_level));

   initial clk_sys = 1'b0;
   always #25 clk_sys = ~clk_sys;

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] mask_of(input logic [3:0] a);
      case (a)
         4'h5: return 16'h033F;
         4'h6: return 16'hFFCF;
         4'h7: return 16'hFFFF;
         4'h8: return 16'hF3FF;
         default: return 16'h0000;
      endcase
   endfunction : mask_of

   function automatic logic [1:0] exp_fld(input int i);
      return 2'(m[OFFS[i]] >> LSBS[i]);
   endfunction : exp_fld

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      reg_rd    <= 1'b0;
      @(posedge clk_sys);
      #1;
      if (mask_of(a) != 16'h0000)
         m[a] = d & mask_of(a);
   endtask : wr

   task automatic rd(input logic [3:0] a);
      reg_addr <= a;
      reg_wr   <= 1'b0;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      #1;
      chk(reg_rdata, (mask_of(a) != 16'h0000) ? m[a] : 16'h0000);
   endtask : rd

   task automatic idle;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk(reg_rdata, 16'h0000);
   endtask : idle

   task automatic check_levels;
      logic [1:0] hi;
      logic [1:0] f;
      hi = 2'h0;
      for (int i = 0; i < 26; i++)
      begin
         f = exp_fld(i);
         chk({14'h0, lv[i]}, {14'h0, f});
         chk({15'h0, src_enabled[i]}, {15'h0, f != 2'h0});
         chk({14'h0, src_rank[2*i+:2]}, {14'h0, (f == 2'h0) ? 2'h0 : f - 2'h1});
         if (f > hi)
            hi = f;
      end
      chk({14'h0, dog}, {14'h0, exp_fld(10)});
      chk({14'h0, top_level}, {14'h0, hi});
   endtask : check_levels

   task automatic read_all;
      for (int a = 5; a <= 8; a++)
         rd(a[3:0]);
   endtask : read_all

   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles >= 5000)
      begin
         n_errors++;
         report_and_stop();
      end
   end

   initial
   begin
      n_errors  = 0;
      checks    = 0;
      cycles    = 0;
      rstn      = 1'b0;
      reg_addr  = 4'h0;
      reg_wdata = 16'h0000;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      for (int a = 5; a <= 8; a++)
         m[a] = 16'h0000;
      void'($urandom(60));
      repeat (16) @(posedge clk_sys);
      #1;
      rstn <= 1'b1;
      @(posedge clk_sys);
      #1;
      check_levels();
      read_all();
      $display("test reset values done");
      // Every code in every field, reserved pairs written with the same code
      for (int c = 1; c <= 4; c++)
      begin
         for (int a = 5; a <= 8; a++)
         begin
            wr(a[3:0], {8{c[1:0]}});
            check_levels();
         end
         read_all();
      end
      idle();
      $display("test field codes done");
      // Write then read the same register back to back
      wr(4'h5, 16'h5A5A);
      rd(4'h5);
      wr(4'h8, 16'hA5A5);
      rd(4'h8);
      check_levels();
      wr(4'h0, 16'hFFFF);
      rd(4'h0);
      wr(4'hF, 16'hFFFF);
      rd(4'hF);
      check_levels();
      for (int n = 0; n < 80; n++)
      begin
         if ($urandom_range(1, 0) == 1)
            wr(4'($urandom_range(15, 0)), 16'($urandom));
         else
            rd(4'($urandom_range(15, 0)));
         check_levels();
      end
      idle();
      $display("test random traffic done");
      wr(4'h7, 16'hFFFF);
      wr(4'h6, 16'hFFFF);
      reg_wr <= 1'b0;
      rstn   <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      rstn <= 1'b1;
      for (int a = 5; a <= 8; a++)
         m[a] = 16'h0000;
      check_levels();
      read_all();
      idle();
      $display("test mid-run reset done");
      report_and_stop();
   end
endmodule : irq_priority_level_regs_tb
